// ### logic/eeprom_pkg.sv
/*
 * Shared constants, carriers and state encoding for the two-wire
 * serial EEPROM slave front end.
 * Assumes a 125 MHz system clock; the link-facing logic runs on its own
 * free-running sample clock.
 */
package eeprom_pkg;

	// Array and page geometry.
	localparam int ADDR_W = 14;
	localparam int PAGE_W = 6;
	localparam int BYTE_W = 8;

	// Device type code expected in the control byte; the value is arbitrary.
	localparam logic [3:0] TYPE_CODE = 4'h5;

	// Write cycle timing.
	localparam int SYS_CLK_HZ = 125_000_000;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLES_DFLT = WRITE_CYCLE_MS * (SYS_CLK_HZ / 1000);

	// Rising clock edges counted within one byte frame.
	localparam logic [3:0] BIT_CNT_DATA = 4'h8;
	localparam logic [3:0] BIT_CNT_ACK = 4'h9;
	localparam logic [3:0] BIT_CNT_ONE = 4'h1;

	// Reset level of the sampled bus lines (idle bus is high).
	localparam logic LINE_IDLE = 1'h1;

	// Sampled bus lines.
	typedef struct packed {
		logic scl;
		logic sda;
	} line_pair_s;

	// Layout of the control byte, direction bit in the least significant place.
	typedef struct packed {
		logic [3:0] code;
		logic [2:0] cs;
		logic rd;
	} ctrl_byte_s;

	// Strap and protect inputs as sampled together.
	typedef struct packed {
		logic [2:0] cs;
		logic wp;
	} strap_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_READ,
		ST_IGNORE
	} phase_e;

endpackage

// ### logic/i2c_serial_eeprom_slave.sv
/*
 * Two-wire serial EEPROM slave: bus front end, page buffer, array and
 * self-timed write cycle.
 * Assumes an external pull-up resolves the data line from o_sda_oe, a
 * free-running link sample clock much faster than the serial clock, and a
 * master that drives the serial clock.
 */
// Overview of operation
// (RULE_01) First byte after START is type code, chip select bits, direction.
// (RULE_02) Respond only when chip select bits match the three strap pins.
// (RULE_03) Direction one selects read, zero selects write.
// (RULE_04) Two address bytes follow, high first; upper two bits ignored.
// (RULE_05) Acknowledge a matching control byte, then read or write.
// (RULE_06) Acknowledge control, address and write data bytes on ninth pulse.
// (RULE_07) STOP after at least one data byte starts the programming cycle.
// (RULE_08) No acknowledge at all while the programming cycle runs.
// (RULE_09) Under write protect acknowledge everything but program nothing.
// (RULE_10) After a byte write the pointer is one above the written byte.
// (RULE_11) Up to 63 further bytes are buffered and programmed after STOP.
// (RULE_12) Only the six low pointer bits step, wrapping within the page.
// (RULE_13) Write protect is sampled at STOP; later changes do not matter.
// (RULE_14) Protect high blocks writes to the whole array.
// (RULE_15) Master polls with write control bytes until acknowledged.
// (RULE_16) Current address read returns the byte after the last accessed.
// (RULE_17) Master ends a read with no acknowledge then STOP; device lets go.
// (RULE_18) Address phase then repeated START loads pointer without writing.
// (RULE_19) An acknowledged read byte is followed by the next address.
// (RULE_20) Sequential reads roll over from the top address to zero.
// (RULE_21) Data falling with clock high is START, rising is STOP.
// (RULE_22) Data changes only while clock is low, one bit per pulse.
// (RULE_23) On a missing read acknowledge the data line is released high.
// (RULE_24) Programming lasts at most 5 ms, then acknowledges resume.
// (RULE_25) A write ended before any data byte programs nothing.
`timescale 1ns/1ps

module i2c_serial_eeprom_slave
	import eeprom_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_W,
	parameter int PAGE_BITS = PAGE_W,
	parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT,
	parameter logic [3:0] DEVICE_TYPE = TYPE_CODE
) (
	// System clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Link sample clock.
	input wire logic i_link_clk,
	// Serial bus, data line as open drain.
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// Straps and write protect.
	input wire logic i_chip_select_pin_2,
	input wire logic i_chip_select_pin_1,
	input wire logic i_chip_select_pin_0,
	input wire logic i_write_protect,
	// Status.
	output logic o_write_busy
);

	localparam int MEM_BYTES = 1 << ADDR_BITS;
	localparam int PAGE_BYTES = 1 << PAGE_BITS;
	localparam int HI_BITS = ADDR_BITS - BYTE_W;
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);
	localparam logic [PAGE_BITS-1:0] IDX_LAST = PAGE_BITS'(PAGE_BYTES - 1);

	// Link-domain reset, synchronised from the system reset.
	logic rst_meta_n;
	logic rst_link_n;

	// Bus line and strap synchronisers.
	line_pair_s pin_meta;
	line_pair_s pin_sync;
	line_pair_s pin_prev;
	strap_s strap_meta;
	strap_s strap_sync;

	// Protocol engine.
	phase_e state;
	logic [3:0] bit_cnt;
	logic [BYTE_W-1:0] rx;
	logic [BYTE_W-1:0] tx;
	logic sda_oe;
	logic [ADDR_BITS-1:0] ptr;
	logic [HI_BITS-1:0] addr_hi;
	logic got_data;
	logic m_ack;
	ctrl_byte_s ctrl;

	// Page buffer, array and commit sequencer.
	logic [BYTE_W-1:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_mask;
	logic [BYTE_W-1:0] mem [MEM_BYTES];
	logic commit_act;
	logic [PAGE_BITS-1:0] commit_idx;
	logic [ADDR_BITS-PAGE_BITS-1:0] commit_base;

	// Write-cycle handshake across the two domains.
	logic prog_req_tog;
	logic ack_meta;
	logic ack_sync;
	logic req_meta;
	logic req_sync;
	logic req_seen;
	logic prog_ack_tog;
	logic [CNT_W-1:0] timer;
	logic write_busy;

	// Decoded link events.
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_done;
	logic ack_done;
	logic busy_link;
	logic cs_match;
	logic buf_wr;
	logic mask_clr;
	logic commit_go;

	always_ff @(posedge i_link_clk) begin
		rst_meta_n <= i_rst_n;
		rst_link_n <= rst_meta_n;
	end

	always_ff @(posedge i_link_clk) begin
		if (!rst_link_n) begin
			pin_meta <= '{scl: LINE_IDLE, sda: LINE_IDLE};
			pin_sync <= '{scl: LINE_IDLE, sda: LINE_IDLE};
			pin_prev <= '{scl: LINE_IDLE, sda: LINE_IDLE};
		end else begin
			pin_meta <= '{scl: i_scl, sda: i_sda};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	always_ff @(posedge i_link_clk) begin
		strap_meta <= '{cs: {i_chip_select_pin_2, i_chip_select_pin_1,
			i_chip_select_pin_0}, wp: i_write_protect};
		strap_sync <= strap_meta;
	end

	always_ff @(posedge i_link_clk) begin
		if (!rst_link_n) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
		end else begin
			ack_meta <= prog_ack_tog;
			ack_sync <= ack_meta;
		end
	end

	assign scl_rise = pin_sync.scl & ~pin_prev.scl;
	assign scl_fall = ~pin_sync.scl & pin_prev.scl;
	// Data edges are only honoured while the clock stays high.
	assign start_det = pin_sync.scl & pin_prev.scl & pin_prev.sda &
		~pin_sync.sda; // [RULE_21]
	assign stop_det = pin_sync.scl & pin_prev.scl & ~pin_prev.sda &
		pin_sync.sda; // [RULE_21]
	assign byte_done = scl_fall & (bit_cnt == BIT_CNT_DATA); // [RULE_22]
	assign ack_done = scl_fall & (bit_cnt == BIT_CNT_ACK);
	assign ctrl = ctrl_byte_s'(rx);
	assign busy_link = (prog_req_tog != ack_sync) | commit_act; // [RULE_08]
	assign cs_match = (ctrl.code == DEVICE_TYPE) &&
		(ctrl.cs == strap_sync.cs); // [RULE_01] [RULE_02]
	assign buf_wr = byte_done & (state == ST_WDATA) & ~start_det & ~stop_det;
	assign mask_clr = byte_done & (state == ST_ADDR_LO) & ~start_det &
		~stop_det;
	// Protect high at STOP drops the whole command, any address.
	assign commit_go = stop_det & (state == ST_WDATA) & got_data &
		~strap_sync.wp; // [RULE_07] [RULE_09] [RULE_13] [RULE_14] [RULE_25]

	always_ff @(posedge i_link_clk) begin
		if (!rst_link_n) begin
			state <= ST_IDLE;
			bit_cnt <= '0;
			rx <= '0;
			tx <= '0;
			sda_oe <= 1'b0;
			ptr <= '0;
			addr_hi <= '0;
			got_data <= 1'b0;
			m_ack <= 1'b0;
			prog_req_tog <= 1'b0;
		end else if (start_det) begin
			// A repeated START abandons buffered data without programming.
			state <= ST_CTRL; // [RULE_18] [RULE_25]
			bit_cnt <= '0;
			sda_oe <= 1'b0;
			got_data <= 1'b0;
		end else if (stop_det) begin
			state <= ST_IDLE;
			bit_cnt <= '0;
			sda_oe <= 1'b0; // [RULE_17]
			got_data <= 1'b0;
			if (commit_go) begin
				prog_req_tog <= ~prog_req_tog; // [RULE_07]
			end
		end else if (state != ST_IDLE) begin
			if (scl_rise) begin
				bit_cnt <= bit_cnt + BIT_CNT_ONE;
				if (bit_cnt == BIT_CNT_DATA) begin
					m_ack <= ~pin_sync.sda;
				end else begin
					rx <= {rx[BYTE_W-2:0], pin_sync.sda}; // [RULE_22]
				end
			end
			if (byte_done) begin
				sda_oe <= 1'b0;
				unique case (state)
					ST_CTRL: begin
						if (cs_match && !busy_link) begin
							sda_oe <= 1'b1; // [RULE_05] [RULE_06] [RULE_08]
							if (ctrl.rd) begin
								state <= ST_READ; // [RULE_03] [RULE_16]
							end else begin
								state <= ST_ADDR_HI; // [RULE_03] [RULE_15]
							end
						end else begin
							state <= ST_IGNORE; // [RULE_02] [RULE_08]
						end
					end
					ST_ADDR_HI: begin
						sda_oe <= 1'b1; // [RULE_06]
						addr_hi <= rx[HI_BITS-1:0]; // [RULE_04]
						state <= ST_ADDR_LO;
					end
					ST_ADDR_LO: begin
						sda_oe <= 1'b1; // [RULE_06]
						ptr <= {addr_hi, rx}; // [RULE_04] [RULE_18]
						state <= ST_WDATA;
					end
					ST_WDATA: begin
						sda_oe <= 1'b1; // [RULE_06] [RULE_09]
						got_data <= 1'b1;
						ptr <= {ptr[ADDR_BITS-1:PAGE_BITS],
							PAGE_BITS'(ptr[PAGE_BITS-1:0] + 1'b1)};
						// [RULE_10] [RULE_12]
					end
					ST_READ: begin
						sda_oe <= 1'b0;
					end
					ST_IGNORE: begin
						sda_oe <= 1'b0;
					end
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
				endcase
			end else if (ack_done) begin
				bit_cnt <= '0;
				sda_oe <= 1'b0;
				if (state == ST_READ) begin
					// The control acknowledge samples as an acknowledge too.
					if (m_ack) begin
						tx <= mem[ptr]; // [RULE_16] [RULE_19]
						ptr <= ptr + 1'b1; // [RULE_19] [RULE_20]
						sda_oe <= ~mem[ptr][BYTE_W-1];
					end else begin
						state <= ST_IGNORE; // [RULE_17] [RULE_23]
					end
				end
			end else if (scl_fall && (state == ST_READ) &&
				(bit_cnt != '0)) begin
				tx <= {tx[BYTE_W-2:0], 1'b0};
				sda_oe <= ~tx[BYTE_W-2]; // [RULE_22]
			end
		end
	end

	generate
		for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
			always_ff @(posedge i_link_clk) begin
				if (!rst_link_n) begin
					page_buf[i] <= '0;
					page_mask[i] <= 1'b0;
				end else if (mask_clr) begin
					page_mask[i] <= 1'b0;
				end else if (buf_wr &&
					(ptr[PAGE_BITS-1:0] == PAGE_BITS'(i))) begin
					page_buf[i] <= rx; // [RULE_11] [RULE_12]
					page_mask[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// The buffer is copied into the array well inside the timed cycle.
	always_ff @(posedge i_link_clk) begin
		if (!rst_link_n) begin
			commit_act <= 1'b0;
			commit_idx <= '0;
			commit_base <= '0;
		end else if (commit_go) begin
			commit_act <= 1'b1; // [RULE_07] [RULE_11]
			commit_idx <= '0;
			commit_base <= ptr[ADDR_BITS-1:PAGE_BITS];
		end else if (commit_act) begin
			commit_idx <= commit_idx + 1'b1;
			if (commit_idx == IDX_LAST) begin
				commit_act <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (commit_act && page_mask[commit_idx]) begin
			mem[{commit_base, commit_idx}] <= page_buf[commit_idx];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_seen <= 1'b0;
		end else begin
			req_meta <= prog_req_tog;
			req_sync <= req_meta;
			req_seen <= req_sync;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			timer <= '0;
			write_busy <= 1'b0;
			prog_ack_tog <= 1'b0;
		end else if (req_sync != req_seen) begin
			timer <= CNT_LOAD; // [RULE_24]
			write_busy <= 1'b1;
		end else if (timer != '0) begin
			timer <= timer - 1'b1;
			if (timer == CNT_LAST) begin
				write_busy <= 1'b0;
				prog_ack_tog <= ~prog_ack_tog; // [RULE_24]
			end
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe = sda_oe;
	assign o_write_busy = write_busy;

endmodule // i2c_serial_eeprom_slave

// ### sim/eeprom_slave_sva.sv
/* Port checker for the serial EEPROM slave.
   Bound to the slave and sees its ports only. */
`timescale 1ns/1ps
module eeprom_slave_sva #(
	parameter int WRITE_CYCLES = 600
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_write_protect,
	input wire logic o_write_busy
);
	int busy_len;
	always_ff @(posedge i_sys_clk) begin
		busy_len <= o_write_busy ? busy_len + 1 : 0;
	end
	property p_oe_scl_low;
		@(posedge i_link_clk) disable iff (!i_rst_n)
		$changed(o_sda_oe) |-> !i_scl;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("drive changed with clock high");
	property p_ack_stands;
		@(posedge i_link_clk) disable iff (!i_rst_n)
		$rose(o_sda_oe) |=> o_sda_oe [*3];
	endproperty
	a_ack_stands: assert property (p_ack_stands)
		else $error("drive dropped early");
	property p_drive_low;
		@(posedge i_link_clk) disable iff (!i_rst_n)
		o_sda_oe |-> !o_sda;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("drive value not low");
	property p_start_quiet;
		@(posedge i_link_clk) disable iff (!i_rst_n)
		i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:6] !o_sda_oe;
	endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("line held after start");
	property p_busy_quiet;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_write_busy |-> !o_sda_oe;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("acknowledge while busy");
	property p_busy_min;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		$rose(o_write_busy) |=> o_write_busy [*8];
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("write cycle too short");
	property p_busy_len;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		$fell(o_write_busy) |->
			busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("write cycle length wrong");
	property p_wp_blocks;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		$rose(o_write_busy) |-> !i_write_protect;
	endproperty
	a_wp_blocks: assert property (p_wp_blocks)
		else $error("write cycle under protect");
endmodule // eeprom_slave_sva

bind i2c_serial_eeprom_slave eeprom_slave_sva #(
	.WRITE_CYCLES(WRITE_CYCLES)
) eeprom_slave_sva_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
	.o_sda_oe(o_sda_oe), .i_write_protect(i_write_protect),
	.o_write_busy(o_write_busy));

// ### sim/i2c_master_model.sv
/* Two-wire bus master model that drives the serial clock.
   Expects the resolved, pulled-up data line back on i_sda. */
`timescale 1ns/1ps
module i2c_master_model #(
	parameter int Q = 48
) (
	// Resolved data line.
	input wire logic i_sda,
	// Bus drive, one means released.
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'h1;
		o_sda = 1'h1;
	end
	task automatic start;
		#Q o_sda = 1'h1;
		#Q o_scl = 1'h1;
		#Q o_sda = 1'h0;
		#Q o_scl = 1'h0;
	endtask
	task automatic stop;
		#Q o_sda = 1'h0;
		#Q o_scl = 1'h1;
		#Q o_sda = 1'h1;
		#Q;
	endtask
	task automatic bit_io(input logic b, output logic r);
		#Q o_sda = b;
		#Q o_scl = 1'h1;
		#Q r = i_sda;
		#Q o_scl = 1'h0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'h1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, d[i]);
		end
		bit_io(!more, r);
	endtask
endmodule // i2c_master_model

// ### sim/tb_top.sv
/* Self-checking bench for the serial EEPROM slave.
   Straps are 101, moved to 010 for part of t_select; the master model drives the bus. */
`timescale 1ns/1ps
module tb_top;
	import eeprom_pkg::*;
	logic clk = 1'h0;
	logic lclk = 1'h0;
	logic rst_n = 1'h0;
	logic wp = 1'h0;
	logic [2:0] straps = 3'h5;
	logic scl, msda, sda, oe, busy;
	int err_total = 0;
	int checks_done = 0;
	always #4 clk = ~clk;
	always #6 lclk = ~lclk;
	assign sda = msda & ~oe;
	i2c_serial_eeprom_slave #(.WRITE_CYCLES(600)) i2c_serial_eeprom_slave_inst (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_scl(scl),
		.i_sda(sda), .o_sda(), .o_sda_oe(oe),
		.i_chip_select_pin_2(straps[2]), .i_chip_select_pin_1(straps[1]),
		.i_chip_select_pin_0(straps[0]),
		.i_write_protect(wp), .o_write_busy(busy));
	i2c_master_model i2c_master_model_inst (.i_sda(sda), .o_scl(scl),
		.o_sda(msda));
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ctl(input logic [3:0] ty, input logic [2:0] cs,
		input logic rd, input logic exp);
		logic a;
		i2c_master_model_inst.start();
		i2c_master_model_inst.wbyte({ty, cs, rd}, a);
		chk("control ack", {7'h0, exp}, {7'h0, a});
	endtask
	task automatic wb(input logic [7:0] d);
		logic a;
		i2c_master_model_inst.wbyte(d, a);
		chk("byte ack", 8'h1, {7'h0, a});
	endtask
	task automatic rb(input logic more, input logic [7:0] exp);
		logic [7:0] d;
		i2c_master_model_inst.rbyte(more, d);
		chk("read data", exp, d);
	endtask
	task automatic addr(input logic [15:0] ad);
		ctl(TYPE_CODE, 3'h5, 1'h0, 1'h1);
		wb(ad[15:8]);
		wb(ad[7:0]);
	endtask
	task automatic wr(input logic [15:0] ad, input int n, input logic [7:0] b);
		addr(ad);
		for (int i = 0; i < n; i++) begin
			wb(b + 8'(i));
		end
		i2c_master_model_inst.stop();
	endtask
	task automatic rd(input logic [15:0] ad, input int n, input logic [7:0] b);
		addr(ad);
		ctl(TYPE_CODE, 3'h5, 1'h1, 1'h1);
		for (int i = 0; i < n; i++) begin
			rb(i < n - 1, b + 8'(i));
		end
		i2c_master_model_inst.stop();
	endtask
	task automatic poll;
		logic a;
		a = 1'h0;
		for (int n = 0; n < 20 && !a; n++) begin
			i2c_master_model_inst.start();
			i2c_master_model_inst.wbyte({TYPE_CODE, 3'h5, 1'h0}, a);
		end
		i2c_master_model_inst.stop();
		chk("poll ack", 8'h1, {7'h0, a});
	endtask
	task automatic t_select;
		for (int c = 0; c < 8; c++) begin
			ctl(TYPE_CODE, 3'(c), 1'h0, c == 5);
		end
		ctl(TYPE_CODE ^ 4'h3, 3'h5, 1'h0, 1'h0);
		// Move the straps: the old select must now be refused.
		straps = 3'h2;
		repeat (4) @(negedge clk);
		ctl(TYPE_CODE, 3'h2, 1'h0, 1'h1);
		ctl(TYPE_CODE, 3'h5, 1'h0, 1'h0);
		i2c_master_model_inst.stop();
		straps = 3'h5;
		repeat (40) @(negedge clk);
		chk("no write cycle", 8'h0, {7'h0, busy});
	endtask
	task automatic t_page;
		wr(16'hc07e, 4, 8'h10);
		repeat (30) @(negedge clk);
		chk("write busy", 8'h1, {7'h0, busy});
		ctl(TYPE_CODE, 3'h5, 1'h0, 1'h0);
		poll();
		rd(16'h0040, 2, 8'h12);
		rd(16'h007e, 2, 8'h10);
	endtask
	task automatic t_byte;
		wr(16'h1235, 1, 8'h3c);
		poll();
		wr(16'h1234, 1, 8'ha5);
		poll();
		ctl(TYPE_CODE, 3'h5, 1'h1, 1'h1);
		rb(1'h0, 8'h3c);
		repeat (8) @(negedge clk);
		chk("released", 8'h0, {7'h0, oe});
		i2c_master_model_inst.stop();
	endtask
	task automatic t_protect;
		wp = 1'h1;
		wr(16'h1235, 1, 8'hff);
		ctl(TYPE_CODE, 3'h5, 1'h0, 1'h1);
		i2c_master_model_inst.stop();
		chk("protect busy", 8'h0, {7'h0, busy});
		wp = 1'h0;
		rd(16'h1235, 1, 8'h3c);
		wr(16'h3fff, 1, 8'h5a);
		repeat (30) @(negedge clk);
		wp = 1'h1;
		poll();
		wp = 1'h0;
		rd(16'h3fff, 1, 8'h5a);
	endtask
	task automatic t_roll;
		wr(16'h0000, 1, 8'h77);
		poll();
		addr(16'hffff);
		ctl(TYPE_CODE, 3'h5, 1'h1, 1'h1);
		rb(1'h1, 8'h5a);
		rb(1'h0, 8'h77);
		i2c_master_model_inst.stop();
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'h1;
		repeat (10) @(negedge clk);
		t_select();
		t_page();
		t_byte();
		t_protect();
		t_roll();
		give_verdict();
	end
	initial begin
		#600_000;
		err_total++;
		give_verdict();
	end
endmodule // tb_top
